// ==== hw/ufl_regs.vh ====
// Constants of the flash loader request interpreter
`ifndef UFL_REGS_VH
`define UFL_REGS_VH
`define UFL_TYPE_IN 8'hC0
`define UFL_TYPE_OUT 8'h40
`define UFL_REQ_WRITE 8'h82
`define UFL_REQ_LAST_ERR 8'h83
`define UFL_REQ_CHECK_APP 8'h84
`define UFL_REQ_ERASE 8'h85
`define UFL_REQ_READ 8'h86
`define UFL_REQ_RESTART 8'hFE
`define UFL_ERR_NONE 8'h00
`define UFL_ERR_LENGTH 8'h02
`define UFL_ERR_VERIFY 8'h05
`define UFL_ERR_RANGE 8'h06
`define UFL_ERR_MISALIGNED 8'h08
`define UFL_APP_FIRST 16'h0400
`define UFL_APP_LAST 16'h77FF
`define UFL_PAGE_MASK 16'h03FF
`define UFL_WRITE_MAX 16'h0C00
`define UFL_ERASED 8'hFF
`define UFL_MS_NS 1000000
`define UFL_CLK_NS 10
`define UFL_MS_CYCLES (`UFL_MS_NS / `UFL_CLK_NS)
`endif

// ==== hw/ufl_ms_timer.v ====
// Millisecond down-counter for the disconnect delay
`timescale 1ns/1ps
`include "ufl_regs.vh"
module ufl_ms_timer #(
    parameter MS_CYCLES = `UFL_MS_CYCLES
) (
    input wire mclk,
    input wire sys_rst,
    input wire start,
    input wire [15:0] ms,
    output reg done
);
    reg [31:0] tick;
    reg [15:0] left;
    reg run;
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            tick <= 32'h00000000;
            left <= 16'h0000;
            run <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                run <= 1'b1;
                left <= ms;
                tick <= 32'h00000000;
            end
            else if (run)
            begin
                if (left == 16'h0000)
                begin
                    run <= 1'b0;
                    done <= 1'b1;
                end
                else if (tick == MS_CYCLES - 1)
                begin
                    tick <= 32'h00000000;
                    left <= left - 16'h0001;
                end
                else
                    tick <= tick + 32'h00000001;
            end
        end
    end
endmodule

// ==== hw/ufl_requests.v ====
// Vendor control-request interpreter of the USB flash loader
`timescale 1ns/1ps
`include "ufl_regs.vh"
module ufl_requests #(
    parameter MS_CYCLES = `UFL_MS_CYCLES
) (
    input wire mclk,
    input wire sys_rst,
    input wire setup_valid,
    input wire [3:0] setup_ep,
    input wire [7:0] bm_request_type,
    input wire [7:0] b_request,
    input wire [15:0] w_value,
    input wire [15:0] w_index,
    input wire [15:0] w_length,
    output reg tx_valid,
    output reg [7:0] tx_data,
    input wire tx_ready,
    input wire rx_valid,
    input wire [7:0] rx_data,
    output reg status_ack,
    output reg status_stall,
    output reg flash_req,
    output reg flash_we,
    output reg flash_erase,
    output reg [15:0] flash_addr,
    output reg [7:0] flash_wdata,
    input wire [7:0] flash_rdata,
    input wire flash_ack,
    output reg dp_pullup_en,
    output reg system_reset
);
// ----------------------------------------
// States
// ----------------------------------------
    localparam S_IDLE = 9'b000000001;
    localparam S_RD = 9'b000000010;
    localparam S_TX = 9'b000000100;
    localparam S_ERASE = 9'b000001000;
    localparam S_WR_RX = 9'b000010000;
    localparam S_WR_PROG = 9'b000100000;
    localparam S_WR_VFY = 9'b001000000;
    localparam S_WAIT = 9'b010000000;
    localparam S_DONE = 9'b100000000;

    reg [8:0] state;
    reg [7:0] cmd;
    reg [15:0] addr;
    reg [15:0] count;
    reg [7:0] last_err;
    reg [7:0] wr_byte;
    reg [7:0] vfy_err;
    reg timer_start;
    wire timer_done;

    wire [16:0] end_addr = {1'b0, w_value} + {1'b0, w_length} - 17'h00001;
    wire in_app = (w_value >= `UFL_APP_FIRST) && (end_addr <= {1'b0, `UFL_APP_LAST});
    wire vendor_in = (bm_request_type == `UFL_TYPE_IN);
    wire vendor_out = (bm_request_type == `UFL_TYPE_OUT);
    // Write checks in priority: length, alignment, range
    reg [7:0] wr_check;
    always @*
    begin
        if (w_length == 16'h0000 || w_length[0] || w_length > `UFL_WRITE_MAX)
            wr_check = `UFL_ERR_LENGTH;
        else if (w_value[0])
            wr_check = `UFL_ERR_MISALIGNED;
        else if (!in_app)
            wr_check = `UFL_ERR_RANGE;
        else
            wr_check = `UFL_ERR_NONE;
    end

    ufl_ms_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(timer_start),
        .ms(addr),
        .done(timer_done)
    );

// ----------------------------------------
// Request engine
// ----------------------------------------
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state <= S_IDLE;
            cmd <= 8'h00;
            addr <= 16'h0000;
            count <= 16'h0000;
            last_err <= `UFL_ERR_NONE;
            wr_byte <= 8'h00;
            vfy_err <= 8'h00;
            timer_start <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            status_ack <= 1'b0;
            status_stall <= 1'b0;
            flash_req <= 1'b0;
            flash_we <= 1'b0;
            flash_erase <= 1'b0;
            flash_addr <= 16'h0000;
            flash_wdata <= 8'h00;
            dp_pullup_en <= 1'b1;
            system_reset <= 1'b0;
        end
        else
        begin
            status_ack <= 1'b0;
            status_stall <= 1'b0;
            timer_start <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (setup_valid && setup_ep == 4'h0)
                    begin
                        cmd <= b_request;
                        addr <= w_value;
                        count <= w_length;
                        vfy_err <= `UFL_ERR_NONE;
                        if (w_index != 16'h0000)
                            status_stall <= 1'b1;
                        else if (vendor_in && b_request == `UFL_REQ_READ)
                        begin
                            if (w_length == 16'h0000 || !in_app)
                                status_stall <= 1'b1;
                            else
                            begin
                                flash_req <= 1'b1;
                                flash_addr <= w_value;
                                state <= S_RD;
                            end
                        end
                        else if (vendor_in && b_request == `UFL_REQ_ERASE && w_length == 16'h0001)
                        begin
                            // Refused erase still answers its status byte
                            if ((w_value & `UFL_PAGE_MASK) != 16'h0000)
                            begin
                                tx_data <= `UFL_ERR_MISALIGNED;
                                tx_valid <= 1'b1;
                                state <= S_TX;
                            end
                            else if (w_value < `UFL_APP_FIRST || w_value > `UFL_APP_LAST)
                            begin
                                tx_data <= `UFL_ERR_RANGE;
                                tx_valid <= 1'b1;
                                state <= S_TX;
                            end
                            else
                            begin
                                flash_req <= 1'b1;
                                flash_erase <= 1'b1;
                                flash_addr <= w_value;
                                state <= S_ERASE;
                            end
                        end
                        else if (vendor_in && w_length == 16'h0001 && b_request == `UFL_REQ_LAST_ERR)
                        begin
                            tx_data <= last_err;
                            tx_valid <= 1'b1;
                            state <= S_TX;
                        end
                        else if (vendor_in && w_length == 16'h0001 && b_request == `UFL_REQ_CHECK_APP)
                        begin
                            flash_req <= 1'b1;
                            flash_addr <= `UFL_APP_FIRST;
                            count <= 16'h0000;
                            state <= S_RD;
                        end
                        else if (vendor_out && b_request == `UFL_REQ_WRITE)
                        begin
                            last_err <= wr_check;
                            vfy_err <= wr_check;
                            state <= S_WR_RX;
                        end
                        else if (vendor_out && b_request == `UFL_REQ_RESTART && w_length == 16'h0000)
                        begin
                            status_ack <= 1'b1;
                            dp_pullup_en <= 1'b0;
                            timer_start <= 1'b1;
                            state <= S_WAIT;
                        end
                        else
                            status_stall <= 1'b1;
                    end
                end
                S_RD:
                begin
                    if (flash_ack)
                    begin
                        flash_req <= 1'b0;
                        if (cmd == `UFL_REQ_CHECK_APP)
                            tx_data <= (flash_rdata != `UFL_ERASED) ? 8'h01 : 8'h00;
                        else
                            tx_data <= flash_rdata;
                        tx_valid <= 1'b1;
                        state <= S_TX;
                    end
                end
                S_TX:
                begin
                    if (tx_ready)
                    begin
                        tx_valid <= 1'b0;
                        if (cmd == `UFL_REQ_READ && count > 16'h0001)
                        begin
                            count <= count - 16'h0001;
                            addr <= addr + 16'h0001;
                            flash_addr <= addr + 16'h0001;
                            flash_req <= 1'b1;
                            state <= S_RD;
                        end
                        else
                        begin
                            status_ack <= 1'b1;
                            state <= S_IDLE;
                        end
                    end
                end
                S_ERASE:
                begin
                    if (flash_ack)
                    begin
                        flash_req <= 1'b0;
                        flash_erase <= 1'b0;
                        tx_data <= `UFL_ERR_NONE;
                        tx_valid <= 1'b1;
                        state <= S_TX;
                    end
                end
                S_WR_RX:
                begin
                    if (count == 16'h0000)
                    begin
                        status_stall <= (last_err != `UFL_ERR_NONE);
                        status_ack <= (last_err == `UFL_ERR_NONE);
                        state <= S_IDLE;
                    end
                    else if (rx_valid)
                    begin
                        // Byte at a time so no block buffer is needed
                        // Only bad parameters drain; a verify error keeps programming
                        if (vfy_err == `UFL_ERR_NONE)
                        begin
                            wr_byte <= rx_data;
                            flash_wdata <= rx_data;
                            flash_addr <= addr;
                            flash_we <= 1'b1;
                            flash_req <= 1'b1;
                            state <= S_WR_PROG;
                        end
                        else
                            count <= count - 16'h0001;
                    end
                end
                S_WR_PROG:
                begin
                    if (flash_ack)
                    begin
                        flash_we <= 1'b0;
                        flash_req <= 1'b0;
                        state <= S_WR_VFY;
                    end
                end
                S_WR_VFY:
                begin
                    if (!flash_req)
                        flash_req <= 1'b1;
                    else if (flash_ack)
                    begin
                        flash_req <= 1'b0;
                        if (flash_rdata != wr_byte)
                            last_err <= `UFL_ERR_VERIFY;
                        addr <= addr + 16'h0001;
                        count <= count - 16'h0001;
                        state <= S_WR_RX;
                    end
                end
                S_WAIT:
                begin
                    if (timer_done)
                    begin
                        system_reset <= 1'b1;
                        state <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    system_reset <= 1'b1;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== bench/ufl_flash_model.sv ====
// Behavioural flash array behind the loader's flash port
`timescale 1ns/1ps
// ----
// Flash model
// ----
module ufl_flash_model (
    input wire mclk,
    input wire flash_req,
    input wire flash_we,
    input wire flash_erase,
    input wire [15:0] flash_addr,
    input wire [7:0] flash_wdata,
    output reg [7:0] flash_rdata,
    output reg flash_ack,
    input wire slow,
    input wire corrupt
);
    reg [7:0] mem [0:65535];
    integer n, k;
    initial
    begin
        for (k = 0; k < 65536; k = k + 1) mem[k] = 8'hFF;
        n = 0;
        flash_ack = 1'b0;
        flash_rdata = 8'h00;
    end
    // Read data flips when not acked, so stale bytes never look valid
    always @(posedge mclk)
    begin
        flash_ack <= 1'b0;
        flash_rdata <= ~flash_rdata;
        if (flash_req && !flash_ack)
        begin
            if (slow && n < 3) n = n + 1;
            else
            begin
                n = 0;
                flash_ack <= 1'b1;
                if (flash_erase) for (k = 0; k < 1024; k = k + 1) mem[{flash_addr[15:10], 10'h000} + k] = 8'hFF;
                else if (flash_we) mem[flash_addr] = corrupt ? ~flash_wdata : flash_wdata;
                else flash_rdata <= mem[flash_addr];
            end
        end
    end
endmodule

// ==== bench/ufl_requests_assertions.sv ====
// Port checks of the loader request interpreter
`timescale 1ns/1ps
`include "ufl_regs.vh"
// ----
// Checker
// ----
module ufl_requests_assertions (
    input wire mclk,
    input wire sys_rst,
    input wire setup_valid,
    input wire [3:0] setup_ep,
    input wire [7:0] bm_request_type,
    input wire [7:0] b_request,
    input wire [15:0] w_value,
    input wire [15:0] w_index,
    input wire [15:0] w_length,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_ready,
    input wire status_ack,
    input wire status_stall,
    input wire flash_req,
    input wire [15:0] flash_addr,
    input wire dp_pullup_en
);
    reg busy;
    wire take = setup_valid && !busy && setup_ep == 4'h0 && w_index == 16'h0000;
    wire rd = take && b_request == `UFL_REQ_READ && bm_request_type == `UFL_TYPE_IN;
    // Busy tracked from outside only; assumes one request at a time
    always @(posedge mclk)
    begin
        if (sys_rst) busy <= 1'b0;
        else if (setup_valid && setup_ep == 4'h0) busy <= 1'b1;
        else if (status_ack || status_stall) busy <= 1'b0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_index_stall: assert property (setup_valid && !busy && setup_ep == 4'h0 && w_index != 16'h0000
        |=> status_stall) else $error("nonzero index not stalled");
    a_ep_ignore: assert property (setup_valid && !busy && setup_ep != 4'h0
        |=> !status_ack && !status_stall) else $error("setup on other endpoint answered");
    a_unknown_stall: assert property (take && !(b_request inside {8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'hFE})
        |=> status_stall) else $error("unknown request not stalled");
    a_type_stall: assert property (take && b_request == `UFL_REQ_READ && bm_request_type != `UFL_TYPE_IN
        |=> status_stall) else $error("wrong request type not stalled");
    a_read_zero: assert property (rd && w_length == 16'h0000 |=> status_stall)
        else $error("zero length read not stalled");
    a_read_range: assert property (rd && (w_value < `UFL_APP_FIRST || w_value > `UFL_APP_LAST) |=> status_stall)
        else $error("read outside application not stalled");
    a_restart_ack: assert property (take && b_request == `UFL_REQ_RESTART && bm_request_type == `UFL_TYPE_OUT
        && w_length == 16'h0000 |=> status_ack && !dp_pullup_en) else $error("restart not acked with pull-up off");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("data byte dropped before taken");
    a_flash_range: assert property (flash_req |-> flash_addr >= `UFL_APP_FIRST && flash_addr <= `UFL_APP_LAST)
        else $error("flash access outside application");
endmodule
bind ufl_requests ufl_requests_assertions ufl_requests_assertions_i (.mclk, .sys_rst, .setup_valid, .setup_ep,
    .bm_request_type, .b_request, .w_value, .w_index, .w_length, .tx_valid, .tx_data, .tx_ready,
    .status_ack, .status_stall, .flash_req, .flash_addr, .dp_pullup_en);

// ==== bench/ufl_requests_tb.sv ====
// Self-checking bench of the loader request interpreter
`timescale 1ns/1ps
`include "ufl_regs.vh"
// ----
// Bench
// ----
module ufl_requests_tb;
    reg mclk = 1'b0;
    reg sys_rst = 1'b1;
    reg setup_valid = 1'b0;
    reg [3:0] setup_ep = 4'h0;
    reg [7:0] bm_request_type = 8'h00, b_request = 8'h00, rx_data = 8'h00;
    reg [15:0] w_value = 16'h0000, w_index = 16'h0000, w_length = 16'h0000;
    reg tx_ready = 1'b0, rx_valid = 1'b0, slow = 1'b0, corrupt = 1'b0;
    wire tx_valid, status_ack, status_stall, flash_req, flash_we, flash_erase, flash_ack, dp_pullup_en, system_reset;
    wire [7:0] tx_data, flash_wdata, flash_rdata;
    wire [15:0] flash_addr;
    logic [7:0] mem_exp [0:65535];
    logic [9:0] sbq [$];
    logic [31:0] seed = 32'hB3154464;
    int n_errors = 0, check_count = 0, k;
    ufl_requests #(.MS_CYCLES(10)) ufl_requests_i (.mclk, .sys_rst, .setup_valid, .setup_ep, .bm_request_type,
        .b_request, .w_value, .w_index, .w_length, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data,
        .status_ack, .status_stall, .flash_req, .flash_we, .flash_erase, .flash_addr, .flash_wdata,
        .flash_rdata, .flash_ack, .dp_pullup_en, .system_reset);
    ufl_flash_model ufl_flash_model_i (.mclk, .flash_req, .flash_we, .flash_erase, .flash_addr,
        .flash_wdata, .flash_rdata, .flash_ack, .slow, .corrupt);
    always #5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic cmp(input logic [9:0] e, input logic [9:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic pop(input logic [9:0] g);
        if (sbq.size() == 0) cmp(10'h3FF, g);
        else cmp(sbq.pop_front(), g);
    endtask
    // Host side stalls at random to stretch the data stage
    always @(posedge mclk)
    begin
        seed = xs(seed);
        tx_ready <= seed[4];
        if (tx_valid && tx_ready) pop({2'b00, tx_data});
        if (status_ack) pop(10'h100);
        if (status_stall) pop(10'h200);
    end
    task automatic wait_status();
        int w;
        w = 0;
        do
        begin
            @(posedge mclk);
            w++;
        end
        while (!(status_ack || status_stall) && w < 20000);
        if (!(status_ack || status_stall)) cmp(10'h100, 10'h000);
    endtask
    task automatic req(input logic [7:0] t, input logic [7:0] r, input logic [15:0] v, input logic [15:0] x,
        input logic [15:0] n);
        setup_valid <= 1'b1;
        bm_request_type <= t;
        b_request <= r;
        w_value <= v;
        w_index <= x;
        w_length <= n;
        @(posedge mclk);
        setup_valid <= 1'b0;
    endtask
    task automatic st(input logic [7:0] t, input logic [7:0] r, input logic [15:0] v, input logic [15:0] x,
        input logic [15:0] n);
        sbq.push_back(10'h200);
        req(t, r, v, x, n);
        wait_status();
    endtask
    task automatic q(input logic [7:0] r, input logic [7:0] e);
        sbq.push_back({2'b00, e});
        sbq.push_back(10'h100);
        req(`UFL_TYPE_IN, r, 16'h0000, 16'h0000, 16'h0001);
        wait_status();
    endtask
    task automatic er(input logic [15:0] a, input logic [7:0] e);
        sbq.push_back({2'b00, e});
        sbq.push_back(10'h100);
        req(`UFL_TYPE_IN, `UFL_REQ_ERASE, a, 16'h0000, 16'h0001);
        wait_status();
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] n);
        int i;
        for (i = 0; i < n; i++) sbq.push_back({2'b00, mem_exp[a + i[15:0]]});
        sbq.push_back(10'h100);
        req(`UFL_TYPE_IN, `UFL_REQ_READ, a, 16'h0000, n);
        wait_status();
    endtask
    // Every write ends with a last-error query of the expected code
    task automatic wr(input logic [15:0] a, input logic [15:0] n, input logic [7:0] e);
        int i, w;
        logic [7:0] b;
        logic go;
        go = e === 8'h00 || e === 8'h05;
        sbq.push_back(e === 8'h00 ? 10'h100 : 10'h200);
        req(`UFL_TYPE_OUT, `UFL_REQ_WRITE, a, 16'h0000, n);
        rx_valid <= 1'b1;
        for (i = 0; go && i < n; i++)
        begin
            seed = xs(seed);
            b = {seed[7] && a + i[15:0] != `UFL_APP_FIRST, seed[6:0]};
            rx_data <= b;
            mem_exp[a + i[15:0]] = b;
            w = 0;
            do
            begin
                @(posedge mclk);
                w++;
            end
            while (!(flash_req && flash_we && flash_ack) && w < 100);
            if (!(flash_req && flash_we && flash_ack)) cmp(10'h001, 10'h000);
        end
        if (go) rx_valid <= 1'b0;
        wait_status();
        rx_valid <= 1'b0;
        q(`UFL_REQ_LAST_ERR, e);
    endtask
    initial
    begin
        repeat (90000) @(posedge mclk);
        n_errors++;
        give_verdict();
    end
    initial
    begin
        for (k = 0; k < 65536; k++) mem_exp[k] = 8'hFF;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        cmp(10'h001, {9'h000, dp_pullup_en});
        q(`UFL_REQ_CHECK_APP, 8'h00);
        er(16'h7400, 8'h00);
        er(16'h7402, 8'h08);
        er(16'h7800, 8'h06);
        er(16'h0000, 8'h06);
        wr(16'h6800, 16'h0C00, 8'h00);
        slow <= 1'b1;
        wr(16'h7402, 16'h0004, 8'h00);
        wr(16'h7400, 16'h0002, 8'h00);
        rd(16'h7400, 16'h0006);
        wr(16'h7401, 16'h0002, 8'h08);
        wr(16'h7400, 16'h0003, 8'h02);
        wr(16'h7400, 16'h0C02, 8'h02);
        wr(16'h7400, 16'h0000, 8'h02);
        wr(16'h0200, 16'h0002, 8'h06);
        corrupt <= 1'b1;
        wr(16'h7408, 16'h0002, 8'h05);
        corrupt <= 1'b0;
        wr(16'h0400, 16'h0002, 8'h00);
        q(`UFL_REQ_CHECK_APP, 8'h01);
        st(`UFL_TYPE_IN, `UFL_REQ_READ, 16'h7400, 16'h0000, 16'h0000);
        st(`UFL_TYPE_IN, `UFL_REQ_READ, 16'h03FF, 16'h0000, 16'h0001);
        st(`UFL_TYPE_IN, `UFL_REQ_READ, 16'h7400, 16'h0001, 16'h0001);
        st(`UFL_TYPE_IN, 8'h90, 16'h0000, 16'h0000, 16'h0001);
        st(`UFL_TYPE_OUT, `UFL_REQ_READ, 16'h7400, 16'h0000, 16'h0001);
        // Setup on another endpoint must draw no status at all
        setup_ep <= 4'h1;
        req(`UFL_TYPE_IN, 8'h90, 16'h0000, 16'h0000, 16'h0001);
        setup_ep <= 4'h0;
        repeat (20) @(posedge mclk);
        sbq.push_back(10'h100);
        req(`UFL_TYPE_OUT, `UFL_REQ_RESTART, 16'h0002, 16'h0000, 16'h0000);
        wait_status();
        cmp(10'h000, {9'h000, dp_pullup_en});
        repeat (15) @(posedge mclk);
        cmp(10'h000, {9'h000, system_reset});
        repeat (30) @(posedge mclk);
        cmp(10'h001, {9'h000, system_reset});
        cmp(10'(sbq.size()), 10'h000);
        give_verdict();
    end
endmodule
